// ===== core/power_startup_sequencer.sv
// Power start-up and reset sequencer driving the main supply enable
//
// Contract
// RQ1: Sequencing time is counted in ticks of the external 32 kHz crystal.
// RQ2: Main supply enable switches the external DC/DC converter on for power-up.
// RQ3: Wake-in-progress goes active as soon as a wake cause appears in hibernate.
// RQ4: Wake-in-progress goes inactive once the cell check for that wake ends.
// RQ5: Outside circuitry asserts the power button input while it is pressed.
// RQ6: Outside circuitry holds the reset button input low while pressed.
// RQ7: Outside circuitry holds timekeeper init low about 230 ms at first power.
// RQ8: Outside monitor raises cell-ok-at-startup once the cell voltage suffices.
// RQ9: Outside monitor pulls cell-low alert low when the cell runs down.
// RQ10: Every switch and cell input passes two flip-flops before use.
`timescale 1ns/1ns
`default_nettype none
module power_startup_sequencer #(
    parameter int unsigned CHECK_TICKS = pwr_seq_pkg::CHECK_TICKS_DEF
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    input wire pwr_seq_pkg::pins_in_t I_PINS,
    output logic O_MAIN_SUPPLY_ENABLE,
    output logic O_WAKE_IN_PROGRESS,
    output logic O_RUNNING,
    output logic O_CELL_LOW_EVENT,
    output logic O_CHECK_FAILED
);
    import pwr_seq_pkg::*;

    localparam logic [CHECK_CNT_W-1:0] CHECK_LOAD = CHECK_CNT_W'(CHECK_TICKS - 1);

    pins_in_t pins_s;
    logic [5:0] pins_raw;
    logic xtal_prev_q;
    logic xtal_prev_d;
    logic tick;
    logic wake_cause;

    seq_state_t state_q;
    seq_state_t state_d;
    logic [CHECK_CNT_W-1:0] cnt_q;
    logic [CHECK_CNT_W-1:0] cnt_d;
    logic supply_q;
    logic supply_d;
    logic wake_q;
    logic wake_d;
    logic run_q;
    logic run_d;
    logic low_evt_q;
    logic low_evt_d;
    logic fail_q;
    logic fail_d;

    // RQ10 two-stage sync
    assign pins_raw = I_PINS;
    pin_sync #(
        .WIDTH(6),
        .IDLE(PINS_IDLE)
    ) u_sync (
        .i_clk(I_CLK_SYS),
        .i_rstn(I_RSTN),
        .i_async(pins_raw),
        .o_sync(pins_s)
    );

    // RQ1 crystal tick
    always_comb begin
        xtal_prev_d = pins_s.crystal_in_a;
        tick = pins_s.crystal_in_a & ~xtal_prev_q;
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            // Idle crystal level, so release of reset makes no false tick
            xtal_prev_q <= PINS_IDLE[0];
        end else begin
            xtal_prev_q <= xtal_prev_d;
        end
    end

    // Power button or reset button both count as wake causes
    assign wake_cause = pins_s.power_button | ~pins_s.reset_button_n;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        low_evt_d = 1'b0;
        fail_d = 1'b0;
        if (!pins_s.timekeeper_init_n) begin
            // Cold start holds everything off
            state_d = ST_HIBERNATE;
            cnt_d = CNT_RST;
        end else begin
            case (state_q)
                // RQ3 wake detect
                ST_HIBERNATE: begin
                    if (wake_cause) begin
                        state_d = ST_CELL_CHECK;
                        cnt_d = CHECK_LOAD;
                    end
                end
                // RQ4 end of check
                ST_CELL_CHECK: begin
                    if (pins_s.cell_ok_at_startup) begin
                        state_d = ST_RUN;
                    end else if (cnt_q == CNT_RST) begin
                        state_d = ST_HIBERNATE;
                        fail_d = 1'b1;
                    end else if (tick) begin
                        // RQ1 timeout in ticks
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!pins_s.cell_low_alert_n) begin
                        state_d = ST_HIBERNATE;
                        low_evt_d = 1'b1;
                    end else if (!pins_s.reset_button_n) begin
                        state_d = ST_SWITCH_RESET;
                    end
                end
                ST_SWITCH_RESET: begin
                    // Restart through the cell check once the button is let go
                    if (pins_s.reset_button_n) begin
                        state_d = ST_CELL_CHECK;
                        cnt_d = CHECK_LOAD;
                    end
                end
                default: begin
                    state_d = ST_HIBERNATE;
                end
            endcase
        end
        // RQ2 supply on outside hibernate
        supply_d = (state_d != ST_HIBERNATE);
        wake_d = (state_d == ST_CELL_CHECK);
        run_d = (state_d == ST_RUN);
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_q <= ST_HIBERNATE;
            cnt_q <= CNT_RST;
            supply_q <= SUPPLY_RST;
            wake_q <= WAKE_RST;
            run_q <= 1'b0;
            low_evt_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            supply_q <= supply_d;
            wake_q <= wake_d;
            run_q <= run_d;
            low_evt_q <= low_evt_d;
            fail_q <= fail_d;
        end
    end

    assign O_MAIN_SUPPLY_ENABLE = supply_q;
    assign O_WAKE_IN_PROGRESS = wake_q;
    assign O_RUNNING = run_q;
    assign O_CELL_LOW_EVENT = low_evt_q;
    assign O_CHECK_FAILED = fail_q;

    property p_wake_rise;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (state_q == ST_HIBERNATE) && wake_cause && pins_s.timekeeper_init_n
        |=> O_WAKE_IN_PROGRESS && O_MAIN_SUPPLY_ENABLE;
    endproperty
    a_wake_rise: assert property (p_wake_rise) else $error("wake not flagged"); // RQ3

    property p_wake_fall;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (state_q == ST_CELL_CHECK) && pins_s.cell_ok_at_startup && pins_s.timekeeper_init_n
        |=> !O_WAKE_IN_PROGRESS && O_RUNNING;
    endproperty
    a_wake_fall: assert property (p_wake_fall) else $error("wake not cleared"); // RQ4

    property p_supply_with_wake;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN)
        $rose(O_WAKE_IN_PROGRESS) |-> O_MAIN_SUPPLY_ENABLE;
    endproperty
    a_supply_with_wake: assert property (p_supply_with_wake) else $error("supply off"); // RQ2

    property p_cold_off;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN)
        !pins_s.timekeeper_init_n |=> !O_MAIN_SUPPLY_ENABLE && !O_WAKE_IN_PROGRESS;
    endproperty
    a_cold_off: assert property (p_cold_off) else $error("supply on in cold start"); // RQ2

    property p_two_stage;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN)
        $rose(pins_s.power_button) |-> $past(I_PINS.power_button, 2);
    endproperty
    a_two_stage: assert property (p_two_stage) else $error("pin used unsynchronised"); // RQ10

    property p_count_on_tick;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (state_q == ST_CELL_CHECK) && (state_d == ST_CELL_CHECK) && !tick
        |=> $stable(cnt_q);
    endproperty
    a_count_on_tick: assert property (p_count_on_tick) else $error("count off tick"); // RQ1

    property p_check_timeout;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (state_q == ST_CELL_CHECK) && (cnt_q == CNT_RST) && !pins_s.cell_ok_at_startup
        && pins_s.timekeeper_init_n
        |=> O_CHECK_FAILED && !O_WAKE_IN_PROGRESS && !O_MAIN_SUPPLY_ENABLE;
    endproperty
    a_check_timeout: assert property (p_check_timeout) else $error("check not ended"); // RQ4

    property p_low_shutdown;
        @(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (state_q == ST_RUN) && !pins_s.cell_low_alert_n && pins_s.timekeeper_init_n
        |=> O_CELL_LOW_EVENT && !O_RUNNING && !O_MAIN_SUPPLY_ENABLE ##1 !O_CELL_LOW_EVENT;
    endproperty
    a_low_shutdown: assert property (p_low_shutdown) else $error("low cell not handled"); // RQ2

    c_wake: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        $rose(O_WAKE_IN_PROGRESS));
    c_run: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        $rose(O_RUNNING));
    c_low: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        O_CELL_LOW_EVENT);
    c_fail: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        O_CHECK_FAILED);
endmodule : power_startup_sequencer
`default_nettype wire

// ===== core/pwr_seq_pkg.sv
// Shared constants, states and pin bundle of the power start-up sequencer
`default_nettype none
package pwr_seq_pkg;

    // Crystal frequency of the slow sequencing clock, in Hz
    localparam int unsigned XTAL_HZ = 32768;
    // Synchroniser depth for every asynchronous pin
    localparam int unsigned SYNC_STAGES = 2;
    // Default time allowed for the cell check, in crystal ticks (one second)
    localparam int unsigned CHECK_TICKS_DEF = XTAL_HZ;
    localparam int unsigned CHECK_CNT_W = 16;
    // Values after reset
    localparam logic SUPPLY_RST = 1'b0;
    localparam logic WAKE_RST = 1'b0;
    localparam logic [CHECK_CNT_W-1:0] CNT_RST = 16'h0000;
    // Idle levels of the pins, loaded into the synchroniser at reset
    localparam logic [5:0] PINS_IDLE = 6'h1B;

    typedef enum logic [1:0] {
        ST_HIBERNATE,
        ST_CELL_CHECK,
        ST_RUN,
        ST_SWITCH_RESET
    } seq_state_t;

    // Bit order matches PINS_IDLE, msb first
    typedef struct packed {
        logic power_button;
        logic reset_button_n;
        logic timekeeper_init_n;
        logic cell_ok_at_startup;
        logic cell_low_alert_n;
        logic crystal_in_a;
    } pins_in_t;

endpackage : pwr_seq_pkg
`default_nettype wire

// ===== core/pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int unsigned WIDTH = 6,
    parameter logic [WIDTH-1:0] IDLE = '0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= IDLE;
            sync_q <= IDLE;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;
endmodule : pin_sync
`default_nettype wire

// ===== sim/ext_supply_model.sv
// Model of the buttons, cell monitor and crystal outside the sequencer
`timescale 1ns/1ns
`default_nettype none
module ext_supply_model
    import pwr_seq_pkg::*;
#(
    parameter int unsigned HALF = 1526
) (
    input wire logic i_clk,
    input wire pwr_seq_pkg::pins_in_t i_ctl,
    output var pwr_seq_pkg::pins_in_t o_pins
);
    int unsigned cnt_q = 0;
    logic xtal_q = 1'h1;
    always_ff @(posedge i_clk) begin
        cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
        if (cnt_q == HALF - 1) begin
            xtal_q <= ~xtal_q;
        end
    end
    assign o_pins = {i_ctl[5:1], xtal_q};
endmodule : ext_supply_model
`default_nettype wire

// ===== sim/power_startup_sequencer_tb.sv
// Self-checking bench of the power start-up sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module power_startup_sequencer_tb;
    import pwr_seq_pkg::*;
    localparam int unsigned TICKS = 4;
    localparam int unsigned HALF = 1526;
    logic clk;
    logic rstn;
    pins_in_t ctl;
    pins_in_t pins;
    logic sup, wake, run, low_ev, fail;
    int errors = 0;
    int n_compared = 0;
    power_startup_sequencer #(.CHECK_TICKS(TICKS)) dut_u (.I_CLK_SYS(clk), .I_RSTN(rstn),
        .I_PINS(pins), .O_MAIN_SUPPLY_ENABLE(sup), .O_WAKE_IN_PROGRESS(wake),
        .O_RUNNING(run), .O_CELL_LOW_EVENT(low_ev), .O_CHECK_FAILED(fail));
    ext_supply_model #(.HALF(HALF)) model_u (.i_clk(clk), .i_ctl(ctl), .o_pins(pins));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic t_wake();
        @(posedge clk) ctl.power_button <= 1'h1;
        step(2);
        `CHK(sup, 1'h0)
        step(1);
        `CHK({sup, wake}, 2'h3)
        @(posedge clk) begin
            ctl.power_button <= 1'h0;
            ctl.cell_ok_at_startup <= 1'h1;
        end
        step(2);
        `CHK({sup, wake, run}, 3'h6)
        step(1);
        `CHK({sup, wake, run}, 3'h5)
        @(posedge clk) ctl.cell_ok_at_startup <= 1'h0;
        $display("test wake done");
    endtask : t_wake
    task automatic t_reset();
        @(posedge clk) ctl.reset_button_n <= 1'h0;
        step(3);
        `CHK({sup, run}, 2'h2)
        @(posedge clk) ctl.reset_button_n <= 1'h1;
        step(3);
        `CHK(wake, 1'h1)
        @(posedge clk) ctl.cell_ok_at_startup <= 1'h1;
        step(3);
        `CHK({wake, run}, 2'h1)
        @(posedge clk) ctl.cell_ok_at_startup <= 1'h0;
        $display("test reset done");
    endtask : t_reset
    task automatic t_low();
        @(posedge clk) ctl.cell_low_alert_n <= 1'h0;
        step(2);
        `CHK(run, 1'h1)
        step(1);
        `CHK({sup, run, low_ev}, 3'h1)
        step(1);
        `CHK({sup, run, low_ev}, 3'h0)
        @(posedge clk) ctl.cell_low_alert_n <= 1'h1;
        $display("test low cell done");
    endtask : t_low
    task automatic t_timeout();
        int cyc;
        @(posedge clk) ctl.power_button <= 1'h1;
        step(3);
        `CHK(wake, 1'h1)
        @(posedge clk) ctl.power_button <= 1'h0;
        cyc = 0;
        while (fail !== 1'h1 && cyc < 20000) begin
            step(1);
            cyc++;
        end
        `CHK(cyc > (TICKS - 2) * 2 * HALF, 1'h1)
        `CHK(cyc <= (TICKS - 1) * 2 * HALF + 4, 1'h1)
        `CHK({sup, wake, fail}, 3'h1)
        step(1);
        `CHK({sup, wake, fail}, 3'h0)
        $display("test timeout done");
    endtask : t_timeout
    task automatic t_init();
        @(posedge clk) ctl.power_button <= 1'h1;
        step(3);
        `CHK(wake, 1'h1)
        @(posedge clk) begin
            ctl.timekeeper_init_n <= 1'h0;
            ctl.power_button <= 1'h0;
        end
        step(3);
        `CHK({sup, wake}, 2'h0)
        @(posedge clk) ctl.timekeeper_init_n <= 1'h1;
        step(4);
        `CHK({sup, wake}, 2'h0)
        @(posedge clk) ctl.reset_button_n <= 1'h0;
        step(3);
        `CHK({sup, wake}, 2'h3)
        @(posedge clk) begin
            ctl.reset_button_n <= 1'h1;
            ctl.timekeeper_init_n <= 1'h0;
        end
        step(3);
        `CHK({sup, wake}, 2'h0)
        $display("test init done");
    endtask : t_init
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    initial begin
        rstn = 1'h0;
        ctl = PINS_IDLE;
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        step(1);
        `CHK({sup, wake, run}, 3'h0)
        t_wake();
        t_reset();
        t_low();
        t_timeout();
        t_init();
        final_report();
    end
    initial begin
        #600000;
        errors++;
        final_report();
    end
endmodule : power_startup_sequencer_tb
`default_nettype wire
